// ---- include/dfs_params.svh ----
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH

`define DFS_CLK_HZ        20000000
`define DFS_TICK_MS       100
`define DFS_TICKS_PER_S   (1000 / `DFS_TICK_MS)
`define DFS_OPL_DELAY_S   5
`define DFS_IMB_DELAY_S   10
`define DFS_TMR_W         20
`define DFS_NUM_TMR       8

`define DFS_OFS_CTRL      12'h000
`define DFS_OFS_PREALARM  12'h004
`define DFS_OFS_PHASE     12'h008
`define DFS_OFS_IMBAL     12'h00c
`define DFS_OFS_PIDLOSS   12'h010
`define DFS_OFS_LINK      12'h014
`define DFS_OFS_DRVOL     12'h018
`define DFS_OFS_MOTOL     12'h01c
`define DFS_OFS_TRIPLIM   12'h020
`define DFS_OFS_STATION   12'h024
`define DFS_OFS_STATUS    12'h028
`define DFS_OFS_MASK      12'h02c
`define DFS_OFS_STATE     12'h030

`define DFS_CTRL_RESET_BIT 31
`define DFS_MSK_CTRL      32'h0000_07ff
`define DFS_MSK_PREALARM  32'h0fff_ffff
`define DFS_MSK_PHASE     32'h007f_01ff
`define DFS_MSK_IMBAL     32'h0000_03ff
`define DFS_MSK_PIDLOSS   32'hffff_03ff
`define DFS_MSK_LINK      32'h03ff_03ff
`define DFS_MSK_OL        32'hffff_00ff
`define DFS_MSK_TRIPLIM   32'h0000_3fff

`define DFS_RST_CTRL      32'h0000_0453
`define DFS_RST_PREALARM  32'h0064_0640
`define DFS_RST_PHASE     32'h0032_000a
`define DFS_RST_IMBAL     32'h0000_0064
`define DFS_RST_PIDLOSS   32'h0064_0000
`define DFS_RST_LINK      32'h000a_0032
`define DFS_RST_DRVOL     32'h003c_0096
`define DFS_RST_MOTOL     32'h0064_0096
`define DFS_RST_TRIPLIM   14'h0005
`define DFS_RST_STATION   8'h01
`define DFS_STATION_MAX   8'hf7
`define DFS_IMB_OFF       10'h064

`define DFS_CODE_OL       8'h09
`define DFS_CODE_PHIN     8'h0c
`define DFS_CODE_PHOUT    8'h0d
`define DFS_CODE_PID      8'h14
`define DFS_CODE_RS485    8'h15
`define DFS_CODE_KEYPAD   8'h16
`define DFS_CODE_NVM      8'h17
`define DFS_ALARM_PRE     8'h09

`endif

// ---- include/dfs_pkg.sv ----
// Types and reaction decoders of the supervisor
package dfs_pkg;

  typedef enum {
    REACT_NONE, REACT_RUN, REACT_HOLD, REACT_COAST, REACT_STOP
  } dfs_react_e;

  typedef struct packed {
    logic [19:0] cnt;
    logic        expired;
  } dfs_tmr_s;

  typedef struct packed {
    logic [31:0] ctrl, pre, phase, imbal, pidl, link, drvol, motol;
    logic [13:0] tripLim, tripCnt;
    logic [7:0]  station, faultCode, alarmCode;
    logic [6:0]  mask, status;
    logic [20:0] tickCnt;
    logic [2:0]  sync;
    logic        phFilt, tick, tripFault, coast, stop, hold, nvmAlarm;
    logic [3:0]  prevAlarm;
    logic        prevLock, pslverr;
    logic [31:0] prdata;
  } dfs_state_s;

  function automatic dfs_react_e dfs_link_react(input logic [1:0] f);
    unique case (f)
      2'h0:    return REACT_COAST;
      2'h1:    return REACT_RUN;
      2'h2:    return REACT_STOP;
      default: return REACT_RUN;
    endcase
  endfunction

  function automatic dfs_react_e dfs_pid_react(input logic [1:0] f);
    unique case (f)
      2'h0: return REACT_NONE;
      2'h1: return REACT_HOLD;
      2'h2: return REACT_COAST;
      2'h3: return REACT_STOP;
    endcase
  endfunction

endpackage

// ---- include/dfs_timer_if.sv ----
// Condition, limit and expiry of one qualification timer
`timescale 1ns/100ps
interface dfs_timer_if;
  logic        cond;
  logic [19:0] limit;
  logic        expired;
  modport ctrl  (output cond, output limit, input expired);
  modport timer (input cond, input limit, output expired);
endinterface

// ---- rtl/dfs_qual_timer.sv ----
// Qualification timer counting 0.1 s ticks while its condition holds
`timescale 1ns/100ps
module dfs_qual_timer (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  tick,
  dfs_timer_if.timer tmr
);
  import dfs_pkg::*;

  dfs_tmr_s st_reg;
  dfs_tmr_s st_next;

  always_comb begin
    st_next = st_reg;
    if (!tmr.cond) begin
      st_next.cnt     = '0;
      st_next.expired = 1'b0;
    end else if (st_reg.cnt >= tmr.limit) begin
      st_next.expired = 1'b1;
    end else if (tick) begin
      st_next.cnt = st_reg.cnt + 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Tick phase is free, so expiry lands up to one tick before the limit
  assign tmr.expired = st_reg.expired;
endmodule

// ---- rtl/drive_fault_supervisor.sv ----
// Fault, alarm and link supervision with APB register access
`timescale 1ns/100ps
`include "dfs_params.svh"

// Contract
// - Current over pre-alarm level for the delay gives pre-alarm, A-09.
// - Phase select: 0 none, 1 output only, 2 input only, 3 both.
// - Input phase loss trips E-12 and coasts after programmable delay.
// - Current over reference fraction for 5 s trips E-13 and coasts.
// - Max/min ratio above coefficient 10 s trips E-13; 1.00 disables.
// - Feedback-loss reaction: none, alarm hold, trip coast, alarm stop.
// - Feedback under threshold for detection time fires the reaction.
// - Loss threshold 0 to 100.0 percent, capped by maximum reference (code accepts any 10-bit setting, up to 1023).
// - RS485 reaction: 0 trip coast, 1 alarm keep running, 2 alarm stop.
// - No RS485 frame within timeout is a fault; zero timeout disables.
// - Keypad reaction: 0 trip coast, 1 protect run, 2 protect stop.
// - No keypad data within its timeout is a fault with that reaction.
// - Memory error: 0 trips and coasts, 1 alarms and keeps running.
// - Mode digit 2 and current at drive threshold for time trips E-09.
// - Hold motor overload threshold and detection time.
// - Count trips; above limit refuse fault reset until power-up (code also ends it when a limit at or above the count is written).
// - Station address 0 to 247; 0 broadcast, others slave addresses.
// - Broadcast address executes host commands but never answers.
module drive_fault_supervisor #(
  parameter int TICK_CYCLES = `DFS_CLK_HZ / 1000 * `DFS_TICK_MS
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] outCurrent,
  input  wire logic [15:0] phaseCurMax,
  input  wire logic [15:0] phaseCurMin,
  input  wire logic [15:0] pidFeedback,
  input  wire logic [15:0] pidRefMax,
  input  wire logic        inPhaseLossPin,
  input  wire logic        rs485FrameOk,
  input  wire logic        keypadFrameOk,
  input  wire logic        nvmError,
  input  wire logic        overcurrent_trip,
  input  wire logic        moduleTrip,
  output logic             preAlarm,
  output logic      [7:0]  alarmCode,
  output logic             tripFault,
  output logic      [7:0]  faultCode,
  output logic             coastStop,
  output logic             rampStop,
  output logic             holdFreq,
  output logic             rs485Alarm,
  output logic             keypadAlarm,
  output logic             pidAlarm,
  output logic             nvmAlarm,
  output logic             resetLocked,
  output logic      [7:0]  stationAddr,
  output logic             txAllow,
  output logic             irq
);
  import dfs_pkg::*;

  localparam int TP = `DFS_TMR_W;
  localparam int T_PRE = 0;
  localparam int T_PHIN = 1;
  localparam int T_PHOUT = 2;
  localparam int T_IMB = 3;
  localparam int T_PID = 4;
  localparam int T_RS = 5;
  localparam int T_KEY = 6;
  localparam int T_DRV = 7;

  dfs_state_s s_reg;
  dfs_state_s s_next;
  dfs_timer_if tif[`DFS_NUM_TMR] ();
  logic [`DFS_NUM_TMR-1:0] exp;
  logic [15:0] pidThr;
  logic [31:0] rdMux;
  logic        rdHit;
  logic        lockout;
  logic        wrAcc;
  logic        resetReq;
  dfs_react_e  pidR;
  dfs_react_e  rsR;
  dfs_react_e  keyR;

  genvar gi;
  generate
    for (gi = 0; gi < `DFS_NUM_TMR; gi++) begin : g_tmr
      dfs_qual_timer u_tmr (
        .clk  (clk),
        .nrst (nrst),
        .tick (s_reg.tick),
        .tmr  (tif[gi])
      );
      assign exp[gi] = tif[gi].expired;
    end
  endgenerate

  // Threshold follows the lower of its setting and the largest reference
  assign pidThr = (16'(s_reg.pidl[9:0]) < pidRefMax) ?
                  16'(s_reg.pidl[9:0]) : pidRefMax;

  assign tif[T_PRE].cond = outCurrent > s_reg.pre[15:0];
  assign tif[T_PRE].limit = TP'(s_reg.pre[27:16]);
  assign tif[T_PHIN].cond = s_reg.ctrl[1] && s_reg.phFilt;
  assign tif[T_PHIN].limit = TP'(s_reg.phase[8:0]);
  assign tif[T_PHOUT].cond = s_reg.ctrl[0] &&
    (32'(outCurrent) > 32'(s_reg.phase[22:16]) * 32'd10);
  assign tif[T_PHOUT].limit = TP'(`DFS_OPL_DELAY_S * `DFS_TICKS_PER_S);
  assign tif[T_IMB].cond = (s_reg.imbal[9:0] != `DFS_IMB_OFF) &&
    (32'(phaseCurMax) * 32'd100 >
     32'(s_reg.imbal[9:0]) * 32'(phaseCurMin));
  assign tif[T_IMB].limit = TP'(`DFS_IMB_DELAY_S * `DFS_TICKS_PER_S);
  assign tif[T_PID].cond = (pidR != REACT_NONE) &&
    (pidFeedback < pidThr);
  assign tif[T_PID].limit = TP'(s_reg.pidl[31:16]);
  // A frame pulse drops the condition for one cycle, restarting the count
  assign tif[T_RS].cond = (s_reg.link[9:0] != 10'h0) && !rs485FrameOk;
  assign tif[T_RS].limit = TP'(s_reg.link[9:0]);
  assign tif[T_KEY].cond = !keypadFrameOk;
  assign tif[T_KEY].limit = TP'(s_reg.link[25:16]);
  assign tif[T_DRV].cond = (s_reg.ctrl[10:9] == 2'h2) &&
    (32'(outCurrent) >= 32'(s_reg.drvol[7:0]) * 32'd10);
  assign tif[T_DRV].limit = TP'(32'(s_reg.drvol[31:16]) * `DFS_TICKS_PER_S);

  assign pidR = dfs_pid_react(s_reg.ctrl[3:2]);
  assign rsR = dfs_link_react(s_reg.ctrl[5:4]);
  assign keyR = dfs_link_react(s_reg.ctrl[7:6]);
  assign lockout = s_reg.tripCnt > s_reg.tripLim;
  assign wrAcc = psel && penable && pwrite;
  assign resetReq = wrAcc && (paddr == `DFS_OFS_CTRL) &&
                    pwdata[`DFS_CTRL_RESET_BIT];

  always_comb begin
    rdHit = 1'b1;
    unique case (paddr)
      `DFS_OFS_CTRL:     rdMux = s_reg.ctrl;
      `DFS_OFS_PREALARM: rdMux = s_reg.pre;
      `DFS_OFS_PHASE:    rdMux = s_reg.phase;
      `DFS_OFS_IMBAL:    rdMux = s_reg.imbal;
      `DFS_OFS_PIDLOSS:  rdMux = s_reg.pidl;
      `DFS_OFS_LINK:     rdMux = s_reg.link;
      `DFS_OFS_DRVOL:    rdMux = s_reg.drvol;
      `DFS_OFS_MOTOL:    rdMux = s_reg.motol;
      `DFS_OFS_TRIPLIM:  rdMux = {2'h0, s_reg.tripCnt, 2'h0, s_reg.tripLim};
      `DFS_OFS_STATION:  rdMux = {24'h0, s_reg.station};
      `DFS_OFS_STATUS:   rdMux = {25'h0, s_reg.status};
      `DFS_OFS_MASK:     rdMux = {25'h0, s_reg.mask};
      `DFS_OFS_STATE:    rdMux = {9'h0, lockout, s_reg.nvmAlarm,
                                  s_reg.hold, s_reg.stop, s_reg.coast,
                                  s_reg.tripFault, exp[T_PRE],
                                  s_reg.faultCode, s_reg.alarmCode};
      default: begin
        rdMux = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.tickCnt == 21'(TICK_CYCLES - 1)) begin
      s_next.tickCnt = 21'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tickCnt = s_reg.tickCnt + 21'h1;
    end
    // Pin level changes only once the two later stages agree
    s_next.sync = {s_reg.sync[1:0], inPhaseLossPin};
    if (s_reg.sync[2] == s_reg.sync[1]) begin
      s_next.phFilt = s_reg.sync[2];
    end

    // Setup phase captures read data so prdata comes from flip-flops
    if (psel && !penable) begin
      s_next.prdata = pwrite ? 32'h0 : rdMux;
      s_next.pslverr = !rdHit;
    end
    if (wrAcc) begin
      unique case (paddr)
        `DFS_OFS_CTRL:     s_next.ctrl = pwdata & `DFS_MSK_CTRL;
        `DFS_OFS_PREALARM: s_next.pre = pwdata & `DFS_MSK_PREALARM;
        `DFS_OFS_PHASE:    s_next.phase = pwdata & `DFS_MSK_PHASE;
        `DFS_OFS_IMBAL:    s_next.imbal = pwdata & `DFS_MSK_IMBAL;
        `DFS_OFS_PIDLOSS:  s_next.pidl = pwdata & `DFS_MSK_PIDLOSS;
        `DFS_OFS_LINK:     s_next.link = pwdata & `DFS_MSK_LINK;
        `DFS_OFS_DRVOL:    s_next.drvol = pwdata & `DFS_MSK_OL;
        `DFS_OFS_MOTOL:    s_next.motol = pwdata & `DFS_MSK_OL;
        `DFS_OFS_TRIPLIM:  s_next.tripLim = pwdata[13:0];
        `DFS_OFS_STATION: begin
          // Out-of-range addresses are dropped, keeping the old one
          if (pwdata[31:0] <= 32'(`DFS_STATION_MAX)) begin
            s_next.station = pwdata[7:0];
          end
        end
        `DFS_OFS_MASK:     s_next.mask = pwdata[6:0];
        default: ;
      endcase
    end
    // Only bits that went out on the bus are cleared by the read
    if (psel && penable && !pwrite && (paddr == `DFS_OFS_STATUS)) begin
      s_next.status = s_reg.status & ~s_reg.prdata[6:0];
    end

    // Only power-up, or a trip limit written at or above the count, ends the lockout
    if ((overcurrent_trip || moduleTrip) && (s_reg.tripCnt != 14'h3fff)) begin
      s_next.tripCnt = s_reg.tripCnt + 14'h1;
    end
    if (resetReq && !lockout) begin
      s_next.tripFault = 1'b0;
      s_next.faultCode = 8'h0;
      s_next.coast = 1'b0;
      s_next.stop = 1'b0;
      s_next.hold = 1'b0;
      s_next.nvmAlarm = 1'b0;
    end

    // Trips are checked in priority order; the first one keeps its code
    if (exp[T_PHIN] && !s_next.tripFault) begin
      s_next.tripFault = 1'b1;
      s_next.faultCode = `DFS_CODE_PHIN;
      s_next.coast = 1'b1;
    end
    if ((exp[T_PHOUT] || exp[T_IMB]) && !s_next.tripFault) begin
      s_next.tripFault = 1'b1;
      s_next.faultCode = `DFS_CODE_PHOUT;
      s_next.coast = 1'b1;
    end
    if (exp[T_DRV] && !s_next.tripFault) begin
      s_next.tripFault = 1'b1;
      s_next.faultCode = `DFS_CODE_OL;
      s_next.coast = 1'b1;
    end
    if (exp[T_PID]) begin
      unique case (pidR)
        REACT_HOLD: s_next.hold = 1'b1;
        REACT_STOP: s_next.stop = 1'b1;
        REACT_COAST: begin
          if (!s_next.tripFault) begin
            s_next.tripFault = 1'b1;
            s_next.faultCode = `DFS_CODE_PID;
            s_next.coast = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (exp[T_RS]) begin
      if (rsR == REACT_STOP) begin
        s_next.stop = 1'b1;
      end else if (rsR == REACT_COAST && !s_next.tripFault) begin
        s_next.tripFault = 1'b1;
        s_next.faultCode = `DFS_CODE_RS485;
        s_next.coast = 1'b1;
      end
    end
    if (exp[T_KEY]) begin
      if (keyR == REACT_STOP) begin
        s_next.stop = 1'b1;
      end else if (keyR == REACT_COAST && !s_next.tripFault) begin
        s_next.tripFault = 1'b1;
        s_next.faultCode = `DFS_CODE_KEYPAD;
        s_next.coast = 1'b1;
      end
    end
    if (nvmError) begin
      if (s_reg.ctrl[8]) begin
        s_next.nvmAlarm = 1'b1;
      end else if (!s_next.tripFault) begin
        s_next.tripFault = 1'b1;
        s_next.faultCode = `DFS_CODE_NVM;
        s_next.coast = 1'b1;
      end
    end

    s_next.alarmCode = exp[T_PRE] ? `DFS_ALARM_PRE : 8'h0;
    s_next.prevAlarm = {exp[T_PRE], exp[T_RS], exp[T_KEY], exp[T_PID]};
    s_next.prevLock = lockout;
    // Hardware set wins over the clear by read in the same cycle
    s_next.status = s_next.status | {
      lockout && !s_reg.prevLock,
      nvmError,
      exp[T_PID] && !s_reg.prevAlarm[0],
      exp[T_KEY] && !s_reg.prevAlarm[1],
      exp[T_RS] && !s_reg.prevAlarm[2],
      s_next.tripFault && !s_reg.tripFault,
      exp[T_PRE] && !s_reg.prevAlarm[3]};
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.ctrl <= `DFS_RST_CTRL;
      s_reg.pre <= `DFS_RST_PREALARM;
      s_reg.phase <= `DFS_RST_PHASE;
      s_reg.imbal <= `DFS_RST_IMBAL;
      s_reg.pidl <= `DFS_RST_PIDLOSS;
      s_reg.link <= `DFS_RST_LINK;
      s_reg.drvol <= `DFS_RST_DRVOL;
      s_reg.motol <= `DFS_RST_MOTOL;
      s_reg.tripLim <= `DFS_RST_TRIPLIM;
      s_reg.station <= `DFS_RST_STATION;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pslverr = psel && penable && s_reg.pslverr;
  assign pready = psel && penable;
  assign preAlarm = exp[T_PRE];
  assign alarmCode = s_reg.alarmCode;
  assign tripFault = s_reg.tripFault;
  assign faultCode = s_reg.faultCode;
  assign coastStop = s_reg.coast;
  assign rampStop = s_reg.stop;
  assign holdFreq = s_reg.hold;
  assign rs485Alarm = exp[T_RS] && (rsR != REACT_COAST);
  assign keypadAlarm = exp[T_KEY] && (keyR != REACT_COAST);
  assign pidAlarm = exp[T_PID] && (pidR == REACT_HOLD || pidR == REACT_STOP);
  assign nvmAlarm = s_reg.nvmAlarm;
  assign resetLocked = lockout;
  assign stationAddr = s_reg.station;
  // Broadcast station still executes but never answers
  assign txAllow = s_reg.station != 8'h0;
  assign irq = |(s_reg.status & s_reg.mask);
endmodule

// ---- sim/dfs_chk.sv ----
// Port assertions of the fault supervisor
`timescale 1ns/100ps
module dfs_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        preAlarm,
  input wire logic [7:0]  alarmCode,
  input wire logic        tripFault,
  input wire logic [7:0]  faultCode,
  input wire logic        coastStop,
  input wire logic        resetLocked,
  input wire logic [7:0]  stationAddr,
  input wire logic        txAllow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rstWr;
  assign rstWr = psel && penable && pwrite && paddr == 12'h000 && pwdata[31];

  property p_tx; txAllow == (stationAddr != 8'h00); endproperty
  a_tx: assert property (p_tx)
    else $error("transmit enable disagrees with station");
  property p_stn; stationAddr <= 8'hf7; endproperty
  a_stn: assert property (p_stn)
    else $error("station address above range");
  property p_pre; preAlarm |-> ##[0:1] alarmCode == 8'h09; endproperty
  a_pre: assert property (p_pre)
    else $error("pre-alarm without its code");
  property p_coast; coastStop |-> tripFault; endproperty
  a_coast: assert property (p_coast)
    else $error("coast without trip");
  // Trips only leave through an accepted fault reset
  property p_fall; $past(nrst) && $fell(tripFault) |-> $past(rstWr); endproperty
  a_fall: assert property (p_fall)
    else $error("trip cleared without reset write");
  property p_keep;
    $past(nrst) && tripFault && $past(tripFault) |-> $stable(faultCode);
  endproperty
  a_keep: assert property (p_keep)
    else $error("fault code changed during trip");
  property p_code;
    $rose(tripFault) |-> faultCode inside {8'h09, 8'h0c, 8'h0d, 8'h14,
                                           8'h15, 8'h16, 8'h17};
  endproperty
  a_code: assert property (p_code)
    else $error("trip with unknown fault code");
  property p_refuse; resetLocked && tripFault && rstWr |=> tripFault;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("fault reset accepted while locked");
  property p_lock; $past(nrst) |-> !$fell(resetLocked); endproperty
  a_lock: assert property (p_lock)
    else $error("lockout released without power cycle");
endmodule

bind drive_fault_supervisor dfs_chk i_chk (
  .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .preAlarm,
  .alarmCode, .tripFault, .faultCode, .coastStop, .resetLocked,
  .stationAddr, .txAllow);

// ---- sim/dfs_host_model.sv ----
// Host and keypad frame sources of the link supervision
`timescale 1ns/100ps
module dfs_host_model #(
  parameter int PERIOD = 6
) (
  input  wire logic clk,
  input  wire logic rsOn,
  input  wire logic kpOn,
  output logic      rs485FrameOk,
  output logic      keypadFrameOk
);
  logic [7:0] cnt = 8'h00;
  initial rs485FrameOk = 1'b0;
  initial keypadFrameOk = 1'b0;
  // Offset pulses so the two links never share a cycle
  always @(posedge clk) begin
    cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
    rs485FrameOk <= rsOn && cnt == 8'h00;
    keypadFrameOk <= kpOn && cnt == 8'h03;
  end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench of the fault supervisor
`timescale 1ns/100ps
`include "dfs_params.svh"
module tb;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, phLoss = 1'b0, nvmErr = 1'b0, ocTrip = 1'b0;
  logic rsOn = 1'b1, kpOn = 1'b1, err, rsOk, kpOk, pready, pslverr;
  logic preAlarm, tripFault, coastStop, rampStop, holdFreq, rs485Alarm;
  logic keypadAlarm, nvmAlarm, resetLocked, txAllow, irq, pidAlarm;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rnd;
  logic [15:0] cur = 16'h0010;
  logic [15:0] curMax = 16'h0010, pidFb = 16'h0100, pidRef = 16'h0080;
  logic [7:0]  alarmCode, faultCode, stationAddr;
  int          mismatches = 0, nTests = 0, seed = 6;
  logic [31:0] rv [10] = '{`DFS_RST_CTRL, `DFS_RST_PREALARM,
    `DFS_RST_PHASE, `DFS_RST_IMBAL, `DFS_RST_PIDLOSS, `DFS_RST_LINK,
    `DFS_RST_DRVOL, `DFS_RST_MOTOL, 32'h5, 32'h1};
  logic [31:0] st [4] = '{32'h0, 32'hf8, 32'hf7, 32'h1};
  logic [7:0]  ex [4] = '{8'h00, 8'h00, 8'hf7, 8'h01};

  always #25 clk = ~clk;

  drive_fault_supervisor #(.TICK_CYCLES(4)) i_dut (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .outCurrent(cur), .phaseCurMax(curMax),
    .phaseCurMin(cur), .pidFeedback(pidFb), .pidRefMax(pidRef),
    .inPhaseLossPin(phLoss), .rs485FrameOk(rsOk), .keypadFrameOk(kpOk),
    .nvmError(nvmErr), .overcurrent_trip(ocTrip), .moduleTrip(1'b0),
    .preAlarm, .alarmCode, .tripFault, .faultCode, .coastStop, .rampStop,
    .holdFreq, .rs485Alarm, .keypadAlarm, .pidAlarm, .nvmAlarm,
    .resetLocked, .stationAddr, .txAllow, .irq);

  dfs_host_model i_host (.clk, .rsOn, .kpOn, .rs485FrameOk(rsOk),
    .keypadFrameOk(kpOk));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // {trip, coast, stop, hold, alarm, code} for a feedback-loss reaction
  function automatic logic [12:0] expPid(input logic [1:0] r);
    case (r)
      2'h0: return 13'h0000;
      2'h1: return 13'h0300;
      2'h2: return {5'b11000, `DFS_CODE_PID};
      default: return 13'h0500;
    endcase
  endfunction

  // {trip, coast, stop, alarm} for a link reaction code
  function automatic logic [3:0] expReact(input logic [1:0] r);
    case (r)
      2'h0: return 4'b1100;
      2'h1: return 4'b0001;
      default: return 4'b0011;
    endcase
  endfunction

  task automatic linkCase(input logic kp, input logic [1:0] r);
    logic [31:0] c;
    c = 32'h403 | ((kp ? {26'h0, r, 2'h1} : {26'h0, 2'h1, r}) << 4);
    apb(1'b1, `DFS_OFS_CTRL, c);
    if (kp) kpOn <= 1'b0;
    else rsOn <= 1'b0;
    repeat (80) @(posedge clk);
    chk({tripFault, coastStop, rampStop, kp ? keypadAlarm : rs485Alarm},
        expReact(r));
    chk(faultCode, r != 2'h0 ? 8'h00 : kp ? 8'h16 : 8'h15);
    rsOn <= 1'b1;
    kpOn <= 1'b1;
    // Let a frame end the expiry, or the reset is overridden at once
    repeat (10) @(posedge clk);
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0453);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize;
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    foreach (rv[i]) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, rv[i]);
    end
    rnd = $random(seed);
    apb(1'b1, `DFS_OFS_MOTOL, rnd);
    apb(1'b0, `DFS_OFS_MOTOL, 32'h0);
    chk(rd, rnd & `DFS_MSK_OL);
    apb(1'b0, 12'h034, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    foreach (st[i]) begin
      apb(1'b1, `DFS_OFS_STATION, st[i]);
      @(posedge clk);
      chk(stationAddr, ex[i]);
      chk(txAllow, ex[i] != 8'h00);
    end
    $display("test registers done");
    apb(1'b1, `DFS_OFS_PREALARM, 32'h0005_0064);
    cur <= 16'h00c8 + {8'h0, 8'($random(seed))};
    repeat (8) @(posedge clk);
    cur <= 16'h0010;
    repeat (2) @(posedge clk);
    cur <= 16'h00c8 + {8'h0, 8'($random(seed))};
    repeat (8) @(posedge clk);
    chk(preAlarm, 1'b0);
    repeat (30) @(posedge clk);
    chk({preAlarm, alarmCode}, 9'h109);
    cur <= 16'h0010;
    $display("test pre-alarm done");
    apb(1'b1, `DFS_OFS_LINK, 32'h0004_0004);
    for (int k = 0; k < 6; k++) linkCase(k[0], 2'(k >> 1));
    apb(1'b1, `DFS_OFS_LINK, 32'h0004_0000);
    rsOn <= 1'b0;
    repeat (80) @(posedge clk);
    chk({tripFault, rs485Alarm}, 2'b00);
    rsOn <= 1'b1;
    $display("test links done");
    apb(1'b1, `DFS_OFS_PHASE, 32'h0032_0002);
    phLoss <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0450 | s);
      repeat (40) @(posedge clk);
      chk({tripFault, coastStop, faultCode}, s > 1 ? 10'h30c : 10'h0);
    end
    phLoss <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0451);
    cur <= 16'h0258;
    repeat (190) @(posedge clk);
    chk(tripFault, 1'b0);
    repeat (30) @(posedge clk);
    chk({tripFault, coastStop, faultCode}, 10'h30d);
    cur <= 16'h0010;
    $display("test phase done");
    apb(1'b1, `DFS_OFS_DRVOL, 32'h0001_0096);
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0053);
    cur <= 16'h0640;
    repeat (60) @(posedge clk);
    chk(tripFault, 1'b0);
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0453);
    repeat (60) @(posedge clk);
    chk({tripFault, faultCode}, 9'h109);
    cur <= 16'h0010;
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0553);
    apb(1'b1, `DFS_OFS_MASK, 32'h20);
    apb(1'b0, `DFS_OFS_STATUS, 32'h0);
    nvmErr <= 1'b1;
    @(posedge clk);
    nvmErr <= 1'b0;
    repeat (3) @(posedge clk);
    chk({tripFault, nvmAlarm, irq}, 3'b011);
    apb(1'b0, `DFS_OFS_STATUS, 32'h0);
    chk(rd[5], 1'b1);
    @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, `DFS_OFS_MASK, 32'h0);
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0453);
    nvmErr <= 1'b1;
    @(posedge clk);
    nvmErr <= 1'b0;
    repeat (3) @(posedge clk);
    chk({irq, tripFault, coastStop, faultCode}, 11'h317);
    $display("test memory error done");
    apb(1'b1, `DFS_OFS_TRIPLIM, 32'h2);
    for (int i = 0; i < 3; i++) begin
      ocTrip <= 1'b1;
      @(posedge clk);
      ocTrip <= 1'b0;
      repeat (2) @(posedge clk);
      chk(resetLocked, i == 2);
    end
    apb(1'b0, `DFS_OFS_TRIPLIM, 32'h0);
    chk(rd[29:16], 14'h3);
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0453);
    @(posedge clk);
    chk(tripFault, 1'b1);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({resetLocked, tripFault}, 2'b00);
    $display("test lockout done");
    apb(1'b1, `DFS_OFS_PIDLOSS, 32'h0005_03e8);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0453 | (32'(r) << 2));
      repeat (30) @(posedge clk);
      chk({holdFreq, pidAlarm}, 2'b00);
      pidFb <= 16'h0040;
      repeat (40) @(posedge clk);
      chk({tripFault, coastStop, rampStop, holdFreq, pidAlarm, faultCode},
          expPid(2'(r)));
      pidFb <= 16'h0100;
    end
    apb(1'b1, `DFS_OFS_CTRL, 32'h8000_0453);
    curMax <= 16'h0030;
    repeat (420) @(posedge clk);
    chk(tripFault, 1'b0);
    apb(1'b1, `DFS_OFS_IMBAL, 32'h0000_00c8);
    repeat (390) @(posedge clk);
    chk(tripFault, 1'b0);
    repeat (20) @(posedge clk);
    chk({tripFault, coastStop, faultCode}, 10'h30d);
    $display("test pid and imbalance done");
    summarize;
  end
endmodule
